// File: verilog/tfc_config_regs.sv
// Purpose: Hysteresis, offset, test and configuration registers of a
//          thermal monitor and fan controller, with fan hysteresis logic
// Assumes: Avalon-MM slave, byte address, 8-bit data in lane 0
// Notes:   Temperatures arrive in quarter degrees from same-clock logic
//
// Summary of operation
// - Fan holds minimum duty until start minus hysteresis
// - Hysteresis nibble spans zero to fifteen degrees
// - Full duty held until limit minus hysteresis
// - Lock bit freezes hysteresis, test, offset, config registers
// - Test enable bit zero selects tree test
// - Signed offset added, quarter degree per step
// - Config bits zero to three pick two-wire sensing
// - Config bit four turns averaging off
// - Config bit five bypasses input divider
// - Config bit six selects single channel conversion
// - Channel select field picks single converted input
// - Fan_pulse_input one pin edge starts conversions
// - Shutdown forces fans off, duty reads zero
// - Above start temperature fan runs minimum duty
// - Limit code 0x80 disables full duty
`timescale 1ns/100ps
`default_nettype none
module tfc_config_regs
  import tfc_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic [9:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [3:0] BYTEENABLE,
  input wire logic [31:0] WRITEDATA,
  output logic [31:0] READDATA,
  output logic WAITREQUEST,
  input wire logic signed [tfc_pkg::TEMP_W-1:0] TEMP_R1,
  input wire logic signed [tfc_pkg::TEMP_W-1:0] TEMP_LOCAL,
  input wire logic signed [tfc_pkg::TEMP_W-1:0] TEMP_R2,
  input wire logic [7:0] FAN_START_TEMP_R1,
  input wire logic [7:0] FAN_START_TEMP_LOCAL,
  input wire logic [7:0] FAN_START_TEMP_R2,
  input wire logic [7:0] OVERTEMP_LIMIT_R1,
  input wire logic [7:0] OVERTEMP_LIMIT_LOCAL,
  input wire logic [7:0] OVERTEMP_LIMIT_R2,
  input wire logic FAN_PULSE_INPUT1,
  output logic signed [tfc_pkg::CORR_W-1:0] CORR_TEMP_R1,
  output logic signed [tfc_pkg::CORR_W-1:0] CORR_TEMP_LOCAL,
  output logic signed [tfc_pkg::CORR_W-1:0] CORR_TEMP_R2,
  output logic [2:0] MINIMUM_DUTY_RUN,
  output logic FULL_DUTY,
  output logic FAN_OFF_LEVEL,
  output logic DUTY_READS_ZERO,
  output logic TREE_TEST_MODE_BIT_OUT,
  output logic [3:0] TWO_WIRE_SENSE,
  output logic AVERAGING_OFF,
  output logic BYPASS_INPUT_DIVIDER,
  output logic SINGLE_CHANNEL_MODE,
  output logic [2:0] CHANNEL_SELECT,
  output logic SINGLE_CHANNEL_MODE_START,
  output logic SHUTDOWN_REQUEST
);
  import tfc_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic ack;
    logic [7:0] rdata;
    logic lock;
    logic polarity_flip;
    logic [7:0] hyst_r1_local;
    logic [7:0] hyst_r2;
    logic tree_test;
    logic [2:0][7:0] offset;
    logic [7:0] second_config;
    logic [2:0] chan_select;
    logic ext_single_channel_mode_clock;
    logic pin_s1;
    logic pin_s2;
    logic pin_d;
    logic single_channel_mode_start;
    logic [2:0][CORR_W-1:0] corr;
    logic [2:0] fan_on;
    logic [2:0] full;
  } tfc_state_s;

  localparam tfc_state_s ST_RESET = '{
    ack: 1'b0, rdata: 8'h00, lock: 1'b0, polarity_flip: 1'b0,
    hyst_r1_local: RST_HYST_R1_LOCAL, hyst_r2: RST_HYST_R2,
    tree_test: 1'b0, offset: {3{RST_OFFSET}},
    second_config: RST_SECOND_CONFIG, chan_select: RST_CHAN_SELECT,
    ext_single_channel_mode_clock: 1'b0, pin_s1: 1'b0, pin_s2: 1'b0, pin_d: 1'b0,
    single_channel_mode_start: 1'b0, corr: '0, fan_on: 3'h0, full: 3'h0};

  tfc_state_s st;
  tfc_state_s next_st;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Whole degrees to quarter degrees, sign kept
  function automatic logic signed [CORR_W-1:0] quarter(input logic [7:0] d);
    quarter = {{2{d[7]}}, d, 2'b00};
  endfunction

  // Hysteresis of a channel in quarter degrees
  function automatic logic signed [CORR_W-1:0] hyst_q(
    input logic [7:0] h_a,
    input logic [7:0] h_b,
    input int ch
  );
    logic [3:0] n;
    n = (ch == 0) ? h_a[7:4] : (ch == 1) ? h_a[3:0] : h_b[7:4];
    hyst_q = {6'h00, n, 2'b00};
  endfunction

  logic [7:0] idx;
  logic req;
  logic acc_wr;
  logic [7:0] wbyte;
  logic [TEMP_W-1:0] temp_in [NUM_TEMP_CH];
  logic [7:0] start_in [NUM_TEMP_CH];
  logic [7:0] limit_in [NUM_TEMP_CH];

  assign idx = ADDRESS[9:2];
  assign req = READ | WRITE;
  assign acc_wr = WRITE & st.ack & BYTEENABLE[0];
  assign wbyte = WRITEDATA[7:0];
  assign temp_in[0] = TEMP_R1;
  assign temp_in[1] = TEMP_LOCAL;
  assign temp_in[2] = TEMP_R2;
  assign start_in[0] = FAN_START_TEMP_R1;
  assign start_in[1] = FAN_START_TEMP_LOCAL;
  assign start_in[2] = FAN_START_TEMP_R2;
  assign limit_in[0] = OVERTEMP_LIMIT_R1;
  assign limit_in[1] = OVERTEMP_LIMIT_LOCAL;
  assign limit_in[2] = OVERTEMP_LIMIT_R2;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    logic signed [CORR_W-1:0] t;
    logic signed [CORR_W-1:0] h;
    logic [7:0] rd;
    t = '0;
    h = '0;
    rd = 8'h00;
    next_st = st;
    // One wait state: request seen, then answered with waitrequest low
    next_st.ack = req & ~st.ack;
    unique case (idx)
      IDX_HYST_R1_LOCAL: rd = st.hyst_r1_local;
      IDX_HYST_R2: rd = st.hyst_r2;
      IDX_TREE_TEST: rd = {7'h00, st.tree_test};
      IDX_OFFSET_R1: rd = st.offset[0];
      IDX_OFFSET_LOCAL: rd = st.offset[1];
      IDX_OFFSET_R2: rd = st.offset[2];
      IDX_SECOND_CONFIG: rd = st.second_config;
      IDX_CHAN_SELECT: rd = {st.chan_select, 5'h00};
      IDX_TEST2: rd = {5'h00, st.ext_single_channel_mode_clock, 2'b00};
      IDX_CONTROL: rd = {6'h00, st.lock, st.polarity_flip};
      default: rd = 8'h00;
    endcase
    if (req && !st.ack)
    begin
      next_st.rdata = rd;
    end
    if (acc_wr)
    begin
      // Locked registers silently keep their contents
      if (!st.lock)
      begin
        unique case (idx)
          IDX_HYST_R1_LOCAL: next_st.hyst_r1_local = wbyte;
          IDX_HYST_R2: next_st.hyst_r2 = {wbyte[7:4], 4'h0};
          IDX_TREE_TEST: next_st.tree_test = wbyte[TREE_TEST_MODE_BIT];
          IDX_OFFSET_R1: next_st.offset[0] = wbyte;
          IDX_OFFSET_LOCAL: next_st.offset[1] = wbyte;
          IDX_OFFSET_R2: next_st.offset[2] = wbyte;
          IDX_SECOND_CONFIG: next_st.second_config = wbyte;
          default: next_st.tree_test = st.tree_test;
        endcase
      end
      unique case (idx)
        IDX_CHAN_SELECT: next_st.chan_select = wbyte[7:CHAN_SELECT_LSB];
        IDX_TEST2: next_st.ext_single_channel_mode_clock = wbyte[EXT_SINGLE_CHANNEL_MODE_CLOCK_BIT];
        IDX_CONTROL:
        begin
          next_st.polarity_flip = wbyte[POLARITY_FLIP_BIT];
          // Lock is sticky until reset
          next_st.lock = st.lock | wbyte[LOCK_BIT];
        end
        default: next_st.lock = st.lock;
      endcase
    end
    // Fan_pulse_input 1 pin passes two flops before the edge detector
    next_st.pin_s1 = FAN_PULSE_INPUT1;
    next_st.pin_s2 = st.pin_s1;
    next_st.pin_d = st.pin_s2;
    next_st.single_channel_mode_start = st.pin_s2 & ~st.pin_d
      & st.second_config[SINGLE_CHANNEL_MODE_BIT] & st.ext_single_channel_mode_clock;
    for (int ch = 0; ch < NUM_TEMP_CH; ch++)
    begin
      t = {{(CORR_W-TEMP_W){temp_in[ch][TEMP_W-1]}}, temp_in[ch]}
        + {{(CORR_W-8){st.offset[ch][7]}}, st.offset[ch]};
      next_st.corr[ch] = t;
      h = hyst_q(st.hyst_r1_local, st.hyst_r2, ch);
      // Fan start with hysteresis band below the start temperature
      if ($signed(st.corr[ch]) > quarter(start_in[ch]))
        next_st.fan_on[ch] = 1'b1;
      else if ($signed(st.corr[ch]) <= quarter(start_in[ch]) - h)
        next_st.fan_on[ch] = 1'b0;
      // Overtemperature full duty, released below limit minus hysteresis
      if (limit_in[ch] == OVERTEMP_DISABLE)
        next_st.full[ch] = 1'b0;
      else if ($signed(st.corr[ch]) > quarter(limit_in[ch]))
        next_st.full[ch] = 1'b1;
      else if ($signed(st.corr[ch]) < quarter(limit_in[ch]) - h)
        next_st.full[ch] = 1'b0;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
      st <= ST_RESET;
    else
      st <= next_st;
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  logic shutdown_request;
  assign shutdown_request = st.second_config[SHUTDOWN_REQUEST_BIT];
  assign WAITREQUEST = req & ~st.ack;
  assign READDATA = {24'h000000, st.rdata};
  assign CORR_TEMP_R1 = st.corr[0];
  assign CORR_TEMP_LOCAL = st.corr[1];
  assign CORR_TEMP_R2 = st.corr[2];
  // Shutdown overrides both minimum and full duty
  assign MINIMUM_DUTY_RUN = st.fan_on & {3{~shutdown_request}};
  assign FULL_DUTY = (|st.full) & ~shutdown_request;
  assign FAN_OFF_LEVEL = st.polarity_flip;
  assign DUTY_READS_ZERO = shutdown_request;
  assign SHUTDOWN_REQUEST = shutdown_request;
  assign TREE_TEST_MODE_BIT_OUT = st.tree_test;
  assign TWO_WIRE_SENSE = st.second_config[3:0];
  assign AVERAGING_OFF = st.second_config[AVERAGING_OFF_BIT];
  assign BYPASS_INPUT_DIVIDER =
    st.second_config[BYPASS_INPUT_DIVIDER_BIT];
  assign SINGLE_CHANNEL_MODE =
    st.second_config[SINGLE_CHANNEL_MODE_BIT];
  assign CHANNEL_SELECT = st.chan_select;
  assign SINGLE_CHANNEL_MODE_START = st.single_channel_mode_start;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  chk_bus_answer: assert property (
    req && WAITREQUEST |=> !WAITREQUEST)
    else $error("request not answered after one wait state");

  chk_lock_offset: assert property (
    st.lock && acc_wr && idx == IDX_OFFSET_R1 |=> $stable(st.offset[0]))
    else $error("locked offset register changed");

  chk_lock_hyst: assert property (
    st.lock && acc_wr && idx == IDX_HYST_R1_LOCAL
      |=> $stable(st.hyst_r1_local))
    else $error("locked hysteresis register changed");

  chk_lock_config: assert property (
    st.lock && acc_wr && idx == IDX_SECOND_CONFIG
      |=> $stable(st.second_config))
    else $error("locked configuration register changed");

  chk_lock_tree: assert property (
    st.lock && acc_wr && idx == IDX_TREE_TEST
      |=> $stable(TREE_TEST_MODE_BIT_OUT))
    else $error("locked tree test bit changed");

  chk_tree_write: assert property (
    !st.lock && acc_wr && idx == IDX_TREE_TEST
      |=> TREE_TEST_MODE_BIT_OUT == $past(WRITEDATA[0]))
    else $error("tree test bit not taken from write");

  chk_offset_sum: assert property (
    1'b1 |=> $signed(st.corr[0])
      == $past(TEMP_R1) + $signed($past(st.offset[0])))
    else $error("corrected temperature mismatch");

  chk_fan_start: assert property (
    $signed(st.corr[0]) > quarter(FAN_START_TEMP_R1) |=> st.fan_on[0])
    else $error("fan did not start above start temperature");

  chk_hyst_hold: assert property (
    st.fan_on[0] && $signed(st.corr[0]) >
      quarter(FAN_START_TEMP_R1) - hyst_q(st.hyst_r1_local, st.hyst_r2, 0)
      |=> st.fan_on[0])
    else $error("fan stopped inside hysteresis band");

  chk_hyst_release: assert property (
    st.fan_on[0] && $signed(st.corr[0]) <=
      quarter(FAN_START_TEMP_R1) - hyst_q(st.hyst_r1_local, st.hyst_r2, 0)
      |=> !st.fan_on[0])
    else $error("fan kept running below hysteresis band");

  chk_full_set: assert property (
    OVERTEMP_LIMIT_R1 != OVERTEMP_DISABLE &&
      $signed(st.corr[0]) > quarter(OVERTEMP_LIMIT_R1) |=> st.full[0])
    else $error("full duty not set above limit");

  chk_full_release: assert property (
    st.full[0] && $signed(st.corr[0]) <
      quarter(OVERTEMP_LIMIT_R1) - hyst_q(st.hyst_r1_local, st.hyst_r2, 0)
      |=> !st.full[0])
    else $error("full duty held below limit minus hysteresis");

  chk_full_off: assert property (
    OVERTEMP_LIMIT_R1 == OVERTEMP_DISABLE |=> !st.full[0])
    else $error("full duty active with limit disabled");

  chk_shutdown_request_fans: assert property (
    $past(next_st.second_config[SHUTDOWN_REQUEST_BIT])
      |-> MINIMUM_DUTY_RUN == 3'h0 && !FULL_DUTY && DUTY_READS_ZERO)
    else $error("fans driven during shutdown");

  chk_single_channel_mode_gate: assert property (
    SINGLE_CHANNEL_MODE_START |-> $past(SINGLE_CHANNEL_MODE) && $past(st.ext_single_channel_mode_clock)
      && $past(st.pin_s2) && !$past(st.pin_d))
    else $error("conversion start outside single channel mode");

  chk_single_channel_mode_pulse: assert property (
    SINGLE_CHANNEL_MODE_START |=> !SINGLE_CHANNEL_MODE_START)
    else $error("conversion start longer than one cycle");
endmodule
`default_nettype wire

// File: verilog/tfc_pkg.sv
// Purpose: Constants for the thermal fan configuration register group
// Assumes: Registers are 8 bits, one per aligned 32-bit word
// Notes:   Byte address is four times the register index
package tfc_pkg;
  // ----------------------------------------------------------------------
  // Register indexes
  // ----------------------------------------------------------------------
  localparam logic [7:0] IDX_CHAN_SELECT = 8'h55;
  localparam logic [7:0] IDX_HYST_R1_LOCAL = 8'h6d;
  localparam logic [7:0] IDX_HYST_R2 = 8'h6e;
  localparam logic [7:0] IDX_TREE_TEST = 8'h6f;
  localparam logic [7:0] IDX_OFFSET_R1 = 8'h70;
  localparam logic [7:0] IDX_OFFSET_LOCAL = 8'h71;
  localparam logic [7:0] IDX_OFFSET_R2 = 8'h72;
  localparam logic [7:0] IDX_SECOND_CONFIG = 8'h73;
  localparam logic [7:0] IDX_TEST2 = 8'h7f;
  localparam logic [7:0] IDX_CONTROL = 8'h80;
  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_HYST_R1_LOCAL = 8'h44;
  localparam logic [7:0] RST_HYST_R2 = 8'h40;
  localparam logic [7:0] RST_TREE_TEST = 8'h00;
  localparam logic [7:0] RST_OFFSET = 8'h00;
  localparam logic [7:0] RST_SECOND_CONFIG = 8'h00;
  localparam logic [2:0] RST_CHAN_SELECT = 3'h0;
  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int TREE_TEST_MODE_BIT = 0;
  localparam int AVERAGING_OFF_BIT = 4;
  localparam int BYPASS_INPUT_DIVIDER_BIT = 5;
  localparam int SINGLE_CHANNEL_MODE_BIT = 6;
  localparam int SHUTDOWN_REQUEST_BIT = 7;
  localparam int CHAN_SELECT_LSB = 5;
  localparam int EXT_SINGLE_CHANNEL_MODE_CLOCK_BIT = 2;
  localparam int POLARITY_FLIP_BIT = 0;
  localparam int LOCK_BIT = 1;
  // ----------------------------------------------------------------------
  // Channel codes and limits
  // ----------------------------------------------------------------------
  localparam logic [2:0] CHAN_INPUT_2V5 = 3'h0;
  localparam logic [2:0] CHAN_SUPPLY = 3'h2;
  localparam logic [2:0] CHAN_REMOTE1 = 3'h5;
  localparam logic [2:0] CHAN_LOCAL = 3'h6;
  localparam logic [2:0] CHAN_REMOTE2 = 3'h7;
  localparam logic [7:0] OVERTEMP_DISABLE = 8'h80;
  localparam int NUM_TEMP_CH = 3;
  localparam int TEMP_W = 10;
  localparam int CORR_W = 12;
endpackage

// File: tb/tfc_config_regs_tb_top.sv
// Purpose: Self-checking bench for the thermal fan configuration registers
// Assumes: One wait state per bus access, fixed temperature path latency
// Notes:   Lock is tested last, since only reset clears it
`timescale 1ns/100ps
`default_nettype none
module tfc_config_regs_tb_top;
  import tfc_pkg::*;
  // ------------------------------------------------------------------
  // Stimulus and design
  // ------------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [9:0] addr = 10'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic waitreq;
  logic signed [9:0] temp [3] = '{10'sd0, 10'sd0, 10'sd0};
  logic [7:0] start [3] = '{8'h7f, 8'h7f, 8'h7f};
  logic [7:0] lim [3] = '{8'h80, 8'h80, 8'h80};
  logic pin1 = 1'b0;
  logic signed [11:0] corr [3];
  logic [2:0] min_run;
  logic full, off_lvl, duty0, tree, averaging_off, byp, single, single_channel_mode, shutdown_request;
  logic [3:0] two_wire;
  logic [2:0] chan;
  int n_fail = 0;
  int cmp_count = 0;
  always #2.5 ref_clk = ~ref_clk;
  tfc_config_regs dut (.REF_CLK(ref_clk), .RST_N(rst_n), .ADDRESS(addr),
    .READ(rd), .WRITE(wr), .BYTEENABLE(4'h1), .WRITEDATA(wdata),
    .READDATA(rdata), .WAITREQUEST(waitreq), .TEMP_R1(temp[0]),
    .TEMP_LOCAL(temp[1]), .TEMP_R2(temp[2]), .FAN_START_TEMP_R1(start[0]),
    .FAN_START_TEMP_LOCAL(start[1]), .FAN_START_TEMP_R2(start[2]),
    .OVERTEMP_LIMIT_R1(lim[0]), .OVERTEMP_LIMIT_LOCAL(lim[1]),
    .OVERTEMP_LIMIT_R2(lim[2]), .FAN_PULSE_INPUT1(pin1),
    .CORR_TEMP_R1(corr[0]), .CORR_TEMP_LOCAL(corr[1]),
    .CORR_TEMP_R2(corr[2]), .MINIMUM_DUTY_RUN(min_run), .FULL_DUTY(full),
    .FAN_OFF_LEVEL(off_lvl), .DUTY_READS_ZERO(duty0),
    .TREE_TEST_MODE_BIT_OUT(tree), .TWO_WIRE_SENSE(two_wire),
    .AVERAGING_OFF(averaging_off), .BYPASS_INPUT_DIVIDER(byp),
    .SINGLE_CHANNEL_MODE(single), .CHANNEL_SELECT(chan), .SINGLE_CHANNEL_MODE_START(single_channel_mode),
    .SHUTDOWN_REQUEST(shutdown_request));
  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task finish_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Request held until the edge that sees waitrequest low
  task bus(input logic w, input logic [7:0] idx, input logic [7:0] d,
           output logic [7:0] q);
    int n;
    n = 0;
    @(posedge ref_clk);
    wr <= w;
    rd <= ~w;
    addr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    // Waitrequest and read data are both taken at the rising edge
    @(posedge ref_clk);
    while (waitreq !== 1'b0 && n < 20)
    begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 20)
    begin
      n_fail++;
      finish_test();
    end
    q = rdata[7:0];
    chk("upper read bits", 32'h0, {rdata[31:8], 8'h0});
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  // Outputs of a write settle after its edge, so look half a cycle on
  task wreg(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, idx, d, q);
    @(negedge ref_clk);
  endtask
  task rchk(input logic [7:0] idx, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, idx, 8'h0, q);
    chk("register read", {24'h0, e}, {24'h0, q});
  endtask
  // Temperature path settles two cycles after the input
  task apply(input int ch, input int v);
    @(posedge ref_clk);
    temp[ch] <= 10'(v);
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task reset_scn;
    logic [7:0] ix [8] = '{8'h6d, 8'h6e, 8'h6f, 8'h70, 8'h71, 8'h72,
                           8'h73, 8'h00};
    logic [7:0] ev [8] = '{8'h44, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00,
                           8'h00, 8'h00};
    for (int i = 0; i < 8; i++)
      rchk(ix[i], ev[i]);
    wreg(8'h00, 8'hff);
    rchk(8'h00, 8'h00);
  endtask
  // Default hysteresis is four degrees, sixteen quarter steps
  task fan_scn(input int ch);
    @(posedge ref_clk);
    start[ch] <= 8'd25;
    lim[ch] <= 8'd30;
    apply(ch, 101);
    chk("fan on", 32'h1, {31'h0, min_run[ch]});
    apply(ch, 121);
    chk("full on", 32'h1, {31'h0, full});
    apply(ch, 110);
    chk("full held", 32'h1, {31'h0, full});
    apply(ch, 103);
    chk("full clear", 32'h0, {31'h0, full});
    apply(ch, 90);
    chk("fan held", 32'h1, {31'h0, min_run[ch]});
    apply(ch, 84);
    chk("fan clear", 32'h0, {31'h0, min_run[ch]});
    @(posedge ref_clk);
    lim[ch] <= 8'h80;
    apply(ch, 121);
    chk("limit off", 32'h0, {31'h0, full});
    @(posedge ref_clk);
    start[ch] <= 8'h7f;
    apply(ch, 0);
  endtask
  task offset_scn(input int ch);
    wreg(8'h70 + 8'(ch), 8'hfc);
    apply(ch, 100);
    chk("corrected", 32'd96, 32'(corr[ch]));
    wreg(8'h70 + 8'(ch), 8'h00);
  endtask
  task cfg_scn;
    logic [2:0] codes [5] = '{3'h0, 3'h2, 3'h5, 3'h6, 3'h7};
    for (int b = 0; b < 8; b++)
    begin
      wreg(8'h73, 8'h1 << b);
      rchk(8'h73, 8'h1 << b);
      chk("config out", 32'h1 << b,
          {24'h0, shutdown_request, single, byp, averaging_off, two_wire});
    end
    for (int i = 0; i < 5; i++)
    begin
      wreg(8'h55, {codes[i], 5'h0});
      chk("channel", {29'h0, codes[i]}, {29'h0, chan});
    end
    wreg(8'h6f, 8'h01);
    chk("tree on", 32'h1, {31'h0, tree});
    wreg(8'h6f, 8'h00);
    chk("tree off", 32'h0, {31'h0, tree});
    wreg(8'h6e, 8'hf0);
    rchk(8'h6e, 8'hf0);
  endtask
  // Counts pulses after a fan_pulse_input rise, with and without the clock enable
  task single_channel_mode_scn(input logic en, input int e);
    int n;
    n = 0;
    wreg(8'h73, 8'h40);
    wreg(8'h7f, {5'h0, en, 2'h0});
    @(posedge ref_clk);
    pin1 <= 1'b1;
    repeat (8)
    begin
      @(negedge ref_clk);
      if (single_channel_mode !== 1'b0)
        n++;
    end
    @(posedge ref_clk);
    pin1 <= 1'b0;
    chk("single_channel_mode pulses", e, n);
  endtask
  task shutdown_request_scn;
    lim[0] <= 8'd10;
    start[0] <= 8'd5;
    wreg(8'h80, 8'h01);
    apply(0, 100);
    chk("full before", 32'h1, {31'h0, full});
    wreg(8'h73, 8'h80);
    chk("off outs", 32'h1, {29'h0, full, min_run[0], duty0});
    chk("off level", 32'h1, {31'h0, off_lvl});
  endtask
  task lock_scn;
    wreg(8'h70, 8'h11);
    wreg(8'h80, 8'h03);
    wreg(8'h70, 8'h22);
    rchk(8'h70, 8'h11);
    wreg(8'h6d, 8'h99);
    rchk(8'h6d, 8'h44);
    wreg(8'h6f, 8'h01);
    rchk(8'h6f, 8'h00);
    wreg(8'h73, 8'h01);
    rchk(8'h73, 8'h80);
  endtask
  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    reset_scn();
    for (int c = 0; c < 3; c++)
      fan_scn(c);
    for (int c = 0; c < 3; c++)
      offset_scn(c);
    cfg_scn();
    single_channel_mode_scn(1'b1, 1);
    single_channel_mode_scn(1'b0, 0);
    shutdown_request_scn();
    lock_scn();
    finish_test();
  end
endmodule
`default_nettype wire
